/* verilog/tmd_decoder.sv */
// crate trigger message decoder: deserialises two 9-bit frames per crossing,
// drives backplane strobes and four status lines; avalon-mm register slave
// assumes serial line, crossing, orbit and gap are pins from other clocks
//
// Our own choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
module tmd_decoder
	import tmd_pkg::*;
(
	input wire logic ref_clk_i, // 10 MHz clock
	input wire logic rst_b_i, // async reset, active low
	input wire logic ser_i, // serial frame line
	input wire logic xing_i, // crossing marker pin
	input wire logic orbit_i, // orbit marker pin
	input wire logic gap_i, // abort gap pin
	input wire logic [3:0] avs_address_i, // byte address
	input wire logic avs_read_i, // read request
	input wire logic avs_write_i, // write request
	input wire logic [31:0] avs_writedata_i, // write data
	output logic [31:0] avs_readdata_o, // read data
	output logic avs_waitrequest_o, // stall
	output tmd_pkg::tmd_bp_s bp_o, // backplane strobes
	output tmd_pkg::tmd_stat_s stat_o, // status lines
	output logic [tmd_pkg::PULSE_W-1:0] pulse_o // calibration pulser fire
);
	import tmd_pkg::*;
	logic ser_s; // synchronised serial line
	logic xing_s; // synchronised crossing
	logic orbit_s; // synchronised orbit
	logic gap_s; // synchronised gap
	// pin synchroniser
	tmd_sync #(.W(4)) u_sync (
		.ref_clk_i(ref_clk_i),
		.rst_b_i(rst_b_i),
		.d_i({ser_i, xing_i, orbit_i, gap_i}),
		.q_o({ser_s, xing_s, orbit_s, gap_s})
	);
	// receive state
	tmd_rx_e st_r, st_nxt; // receive state
	logic [8:0] sh_r, sh_nxt; // shift register
	logic [3:0] cnt_r, cnt_nxt; // bits received
	logic xing_d_r, xing_d_nxt; // delayed crossing for edge
	logic ser_d_r, ser_d_nxt; // delayed serial for start edge
	logic ph_r, ph_nxt; // second clock of a serial bit, skipped
	logic synced_r, synced_nxt; // pipeline aligned to orbit
	// outputs and status
	tmd_bp_s bp_r, bp_nxt; // backplane register
	tmd_stat_s st_o_r, st_o_nxt; // status register
	logic [PULSE_W-1:0] pul_r, pul_nxt; // pulser fire register
	logic [PULSE_W-1:0] pen_r, pen_nxt; // pulser enables
	logic [1:0] full_r, full_nxt; // storage full, front end busy
	logic ferr_r, ferr_nxt; // fatal error latch
	logic [NUM_BUFS-1:0] busy_r, busy_nxt; // buffers holding first-level data
	logic [31:0] rd_r, rd_nxt; // read data
	logic wr_r, wr_nxt; // waitrequest
	logic xing_rise; // crossing edge
	logic frame_end; // ninth bit seen
	logic [8:0] fr; // completed frame
	// receive and decode path
	always_comb begin
		st_nxt = st_r;
		sh_nxt = sh_r;
		cnt_nxt = cnt_r;
		xing_d_nxt = xing_s;
		ser_d_nxt = ser_s;
		ph_nxt = 1'b0;
		synced_nxt = synced_r;
		bp_nxt = bp_r;
		pul_nxt = '0;
		busy_nxt = busy_r;
		st_o_nxt = st_o_r;
		xing_rise = xing_s && !xing_d_r;
		frame_end = 1'b0;
		fr = {sh_r[7:0], ser_s};
		// one-cycle strobes fall back each clock
		bp_nxt.l1_acc = 1'b0;
		bp_nxt.l1_rej = 1'b0;
		bp_nxt.l2_acc = 1'b0;
		bp_nxt.l2_rej = 1'b0;
		bp_nxt.cal = 1'b0;
		bp_nxt.halt = 1'b0;
		bp_nxt.prst = 1'b0;
		bp_nxt.start = 1'b0;
		st_o_nxt.rel = 1'b0;
		// timing fan-out; gap means no collision this crossing
		bp_nxt.xing = xing_s;
		bp_nxt.orbit = orbit_s;
		bp_nxt.gap = gap_s;
		// resync on the orbit marker after reset
		if (!synced_r && orbit_s) begin
			synced_nxt = 1'b1;
		end
		// a crossing edge restarts frame reception once synced to the orbit
		if (xing_rise && synced_r) begin
			st_nxt = ST_F1;
			cnt_nxt = 4'h0;
		end else begin
			case (st_r)
				ST_IDLE: begin
					cnt_nxt = 4'h0;
				end
				ST_F1, ST_F2: begin
					// frame starts on a high start bit; each bit stands two clocks,
					// since the pin filter drops one-clock levels, so take every second
					if ((cnt_r == 4'h0 && ser_s && !ser_d_r) || (cnt_r != 4'h0 && !ph_r)) begin
						sh_nxt = fr;
						cnt_nxt = cnt_r + 4'h1;
						ph_nxt = 1'b1;
						if (cnt_r == 4'(FRAME_BITS - 1)) begin
							frame_end = 1'b1;
							cnt_nxt = 4'h0;
							st_nxt = (st_r == ST_F1) ? ST_F2 : ST_IDLE;
						end
					end
				end
				default: begin
					st_nxt = ST_IDLE;
				end
			endcase
		end
		// first frame: first-level verdict for the leaving crossing
		if (frame_end && st_r == ST_F1) begin
			bp_nxt.l1_buf = fr[BUF_LSB+1:BUF_LSB];
			if (fr[F1_ACC_BIT] && !gap_s) begin
				bp_nxt.l1_acc = 1'b1;
				busy_nxt[fr[BUF_LSB+1:BUF_LSB]] = 1'b1;
			end else begin
				bp_nxt.l1_rej = 1'b1;
			end
		end
		// second frame: type decode
		if (frame_end && st_r == ST_F2) begin
			case (fr[TYPE_MSB:TYPE_LSB])
				TYPE_L2: begin
					bp_nxt.l2_buf = fr[BUF_LSB+1:BUF_LSB];
					if (fr[L2_ACC_BIT]) begin
						bp_nxt.l2_acc = 1'b1;
						st_o_nxt.done = 1'b0;
						st_o_nxt.wait_l = full_r[0];
					end else begin
						bp_nxt.l2_rej = 1'b1;
						st_o_nxt.rel = 1'b1;
					end
					busy_nxt[fr[BUF_LSB+1:BUF_LSB]] = 1'b0;
				end
				TYPE_CAL: begin
					bp_nxt.cal = 1'b1;
					pul_nxt = pen_r;
				end
				TYPE_CTL: begin
					bp_nxt.rdo_type = fr[RDO_MSB:RDO_LSB];
					bp_nxt.halt = (fr[CMD_MSB:CMD_LSB] == CMD_HALT);
					bp_nxt.prst = (fr[CMD_MSB:CMD_LSB] == CMD_RESET);
					bp_nxt.start = (fr[CMD_MSB:CMD_LSB] == CMD_START);
					if (fr[CMD_MSB:CMD_LSB] == CMD_RESET) begin
						synced_nxt = 1'b0;
						busy_nxt = '0;
					end
				end
				default: begin
					// unknown code: strobes stay low, held fields kept
					bp_nxt.l2_buf = bp_r.l2_buf;
				end
			endcase
		end
		// done returns once the front end is free, wait clears with storage
		if (!st_o_r.done && !full_r[1] && !bp_nxt.l2_acc) begin
			st_o_nxt.done = 1'b1;
		end
		if (st_o_r.wait_l && !full_r[0]) begin
			st_o_nxt.wait_l = 1'b0;
		end
		st_o_nxt.err = ferr_r;
	end
	// bus slave: one wait state, answer on second cycle
	always_comb begin
		rd_nxt = rd_r;
		wr_nxt = 1'b1;
		pen_nxt = pen_r;
		full_nxt = full_r;
		ferr_nxt = ferr_r;
		// a request seen with waitrequest high is answered on the next edge
		if ((avs_read_i || avs_write_i) && wr_r) begin
			wr_nxt = 1'b0;
		end
		if (!wr_r) begin
			wr_nxt = 1'b1;
		end
		// a write lands only on the edge at which waitrequest is low
		if (avs_write_i && !wr_r) begin
			case (avs_address_i)
				REG_CTRL: begin
					// fatal error set wins over clear
					ferr_nxt = avs_writedata_i[0] | (ferr_r & ~avs_writedata_i[1]);
				end
				REG_PULSE: pen_nxt = avs_writedata_i[PULSE_W-1:0];
				REG_FULL: full_nxt = avs_writedata_i[1:0];
				default: begin
					ferr_nxt = ferr_r;
				end
			endcase
		end
		// read data is fetched one edge early so it stands with waitrequest low
		if (avs_read_i && wr_r) begin
			case (avs_address_i)
				REG_CTRL: rd_nxt = {31'h0, ferr_r};
				REG_STAT: rd_nxt = {21'h0, busy_r, synced_r, st_r, st_o_r};
				REG_PULSE: rd_nxt = {24'h0, pen_r};
				REG_FULL: rd_nxt = {30'h0, full_r};
				default: rd_nxt = BAD_READ;
			endcase
		end
	end
	// state registers
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_r <= ST_IDLE;
			sh_r <= 9'h000;
			cnt_r <= 4'h0;
			xing_d_r <= 1'b0;
			ser_d_r <= 1'b0;
			ph_r <= 1'b0;
			synced_r <= 1'b0;
			bp_r <= '0;
			st_o_r <= 4'h8; // done high, rest idle
			pul_r <= '0;
			pen_r <= '0;
			full_r <= 2'h0;
			ferr_r <= 1'b0;
			busy_r <= '0;
			rd_r <= 32'h00000000;
			wr_r <= 1'b1;
		end else begin
			st_r <= st_nxt;
			sh_r <= sh_nxt;
			cnt_r <= cnt_nxt;
			xing_d_r <= xing_d_nxt;
			ser_d_r <= ser_d_nxt;
			ph_r <= ph_nxt;
			synced_r <= synced_nxt;
			bp_r <= bp_nxt;
			st_o_r <= st_o_nxt;
			pul_r <= pul_nxt;
			pen_r <= pen_nxt;
			full_r <= full_nxt;
			ferr_r <= ferr_nxt;
			busy_r <= busy_nxt;
			rd_r <= rd_nxt;
			wr_r <= wr_nxt;
		end
	end
	assign bp_o = bp_r;
	assign stat_o = st_o_r;
	assign pulse_o = pul_r;
	assign avs_readdata_o = rd_r;
	assign avs_waitrequest_o = wr_r;
endmodule

/* verilog/tmd_pkg.sv */
// package for the crate trigger message decoder: frame layout, codes, timing counts
// assumes a 10 MHz core clock and 32-bit avalon-mm register access
package tmd_pkg;
	// frame format
	localparam int FRAME_BITS = 9; // bits in one serial frame
	localparam int NUM_BUFS = 4; // second-level buffers
	// timing
	localparam int CLK_PERIOD_NS = 100; // core clock period
	localparam int XING_NS = 132; // crossing period
	localparam int FILLED_NS = 396; // filled bunch spacing
	// first frame: bit8 start, bit2 accept, bits1:0 buffer
	localparam int F1_ACC_BIT = 2; // first-level accept bit
	localparam int BUF_LSB = 0; // buffer index field low bit
	// second frame: bit8 start, bits7:6 type, bits1:0 buffer
	localparam int TYPE_MSB = 7; // message type high bit
	localparam int TYPE_LSB = 6; // message type low bit
	localparam int L2_ACC_BIT = 2; // second-level accept bit
	localparam int CMD_MSB = 4; // control command high bit
	localparam int CMD_LSB = 3; // control command low bit
	localparam int RDO_MSB = 2; // readout type high bit
	localparam int RDO_LSB = 0; // readout type low bit
	localparam logic [1:0] TYPE_L2 = 2'h0; // second-level decision
	localparam logic [1:0] TYPE_CAL = 2'h1; // calibration enable
	localparam logic [1:0] TYPE_CTL = 2'h2; // control message
	localparam logic [1:0] CMD_HALT = 2'h1; // halt pipeline
	localparam logic [1:0] CMD_RESET = 2'h2; // reset pipeline
	localparam logic [1:0] CMD_START = 2'h3; // start pipeline
	// registers (word addresses on a byte bus)
	localparam logic [3:0] REG_CTRL = 4'h0; // control: bit0 fatal error set, bit1 error clear
	localparam logic [3:0] REG_STAT = 4'h4; // status
	localparam logic [3:0] REG_PULSE = 4'h8; // pulser enables
	localparam logic [3:0] REG_FULL = 4'hC; // bit0 readout storage full, bit1 front end busy
	localparam logic [31:0] BAD_READ = 32'hDEADBEEF; // unmapped read data
	// pulser enable width
	localparam int PULSE_W = 8; // pulser enable bits
	// decoded backplane strobes
	typedef struct packed {
		logic l1_acc; // first-level accept
		logic l1_rej; // first-level reject
		logic [1:0] l1_buf; // target buffer
		logic l2_acc; // second-level accept
		logic l2_rej; // second-level reject
		logic [1:0] l2_buf; // buffer of second-level decision
		logic cal; // calibration strobe
		logic halt; // halt pipeline
		logic prst; // pipeline reset
		logic start; // pipeline start
		logic [2:0] rdo_type; // readout type
		logic xing; // crossing marker
		logic orbit; // orbit marker
		logic gap; // abort gap crossing
	} tmd_bp_s;
	// status lines to the supervisor
	typedef struct packed {
		logic done; // front end ready
		logic err; // fatal error
		logic wait_l; // storage backed up
		logic rel; // buffer release
	} tmd_stat_s;
	// receive states, gray from idle through both frames; second frame back to idle flips both bits
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_F1 = 2'b01,
		ST_F2 = 2'b11
	} tmd_rx_e;
endpackage

/* verilog/tmd_sync.sv */
// three-stage synchroniser with second/third agreement filter
// assumes inputs are asynchronous to ref_clk_i
`timescale 1ns/1ps
module tmd_sync #(
	parameter int W = 1 // number of lines
) (
	input wire logic ref_clk_i, // core clock
	input wire logic rst_b_i, // async reset, active low
	input wire logic [W-1:0] d_i, // raw pins
	output logic [W-1:0] q_o // filtered level
);
	logic [W-1:0] s1_r; // first stage, read only by s2
	logic [W-1:0] s2_r; // second stage
	logic [W-1:0] s3_r; // third stage
	logic [W-1:0] q_r; // accepted level
	logic [W-1:0] q_nxt; // next accepted level
	// one filter per line
	genvar g;
	for (g = 0; g < W; g++) begin : g_line
		always_comb begin
			q_nxt[g] = (s2_r[g] == s3_r[g]) ? s2_r[g] : q_r[g];
		end
	end
	// register chain
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			q_r <= '0;
		end else begin
			s1_r <= d_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
			q_r <= q_nxt;
		end
	end
	assign q_o = q_r;
endmodule

/* test/tmd_decoder_checker.sv */
// checker for the trigger message decoder, bound onto the decoder
// assumes one core clock domain and the package codes
`timescale 1ns/1ps
module tmd_decoder_checker
	import tmd_pkg::*;
(
	input logic ref_clk_i, // core clock
	input logic rst_b_i, // async reset, active low
	input logic avs_write_i, // write request
	input logic xing_i, // crossing pin
	input logic orbit_i, // orbit pin
	input tmd_pkg::tmd_bp_s bp_o, // strobes
	input tmd_pkg::tmd_stat_s stat_o, // status lines
	input logic [tmd_pkg::PULSE_W-1:0] pulse_o // pulser fire
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i);
	l1_excl_a: assert property (!(bp_o.l1_acc && bp_o.l1_rej))
		else $error("l1 accept and reject together");
	l1_pulse_a: assert property (bp_o.l1_acc |=> !bp_o.l1_acc)
		else $error("l1 accept longer than one cycle");
	msg_one_a: assert property ($onehot0({bp_o.l2_acc, bp_o.l2_rej, bp_o.cal,
		bp_o.halt, bp_o.prst, bp_o.start})) else $error("two second frame strobes");
	cal_only_a: assert property (pulse_o != 8'h00 |-> bp_o.cal)
		else $error("pulser fire without calibration");
	done_drop_a: assert property (bp_o.l2_acc |-> ##[0:2] !stat_o.done)
		else $error("done kept after accept");
	err_cause_a: assert property ($rose(stat_o.err) |-> $past(avs_write_i, 2))
		else $error("error raised without write");
	xing_fan_a: assert property ($rose(xing_i) ##1 xing_i |-> ##4 bp_o.xing)
		else $error("crossing marker not fanned out");
	orbit_fan_a: assert property ($rose(orbit_i) ##1 orbit_i |-> ##4 bp_o.orbit)
		else $error("orbit marker not fanned out");
	wait_cause_a: assert property ($rose(stat_o.wait_l) |->
		bp_o.l2_acc || $past(bp_o.l2_acc)) else $error("wait without accept");
	rel_cause_a: assert property (stat_o.rel |->
		bp_o.l2_rej || $past(bp_o.l2_rej)) else $error("release without reject");
	gap_rej_a: assert property (bp_o.l1_acc |-> !bp_o.gap)
		else $error("accept in gap");
	rst_idle_a: assert property ($rose(rst_b_i) |-> stat_o == 4'b1000)
		else $error("status not idle after reset");
endmodule
bind tmd_decoder tmd_decoder_checker u_chk (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
	.avs_write_i(avs_write_i), .xing_i(xing_i), .orbit_i(orbit_i), .bp_o(bp_o),
	.stat_o(stat_o), .pulse_o(pulse_o));

/* test/tmd_sup_model.sv */
// supervisor model: crossing marker then two serial frames per request
// assumes go_i is raised for one cycle while busy_o is low
`timescale 1ns/1ps
module tmd_sup_model (
	input logic ref_clk_i, // core clock
	input logic go_i, // start a crossing
	input logic [8:0] f1_i, // first frame
	input logic [8:0] f2_i, // second frame
	output logic ser_o, // serial line
	output logic xing_o, // crossing marker
	output logic busy_o // crossing in progress
);
	initial begin
		ser_o = 1'b0;
		xing_o = 1'b0;
		busy_o = 1'b0;
	end
	// one frame msb first, each bit two clocks for the pin filter, then idle low
	task send(input logic [8:0] f);
		for (int i = 8; i >= 0; i--) begin
			ser_o <= f[i];
			repeat (2) @(posedge ref_clk_i);
		end
		ser_o <= 1'b0;
		repeat (3) @(posedge ref_clk_i);
	endtask
	// each crossing carries both frames at a fixed pace
	always @(posedge ref_clk_i) begin
		if (go_i && !busy_o) begin
			busy_o <= 1'b1;
			xing_o <= 1'b1;
			repeat (2) @(posedge ref_clk_i);
			xing_o <= 1'b0;
			repeat (4) @(posedge ref_clk_i);
			send(f1_i);
			send(f2_i);
			busy_o <= 1'b0;
		end
	end
endmodule

/* test/tmd_decoder_test.sv */
// bench for the trigger message decoder with a supervisor model
// assumes the hand-over timing of the bus and the serial link
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; \
	$display("wrong value %s exp %h got %h", n, e, g); end end
module tmd_decoder_test;
	import tmd_pkg::*;
	logic ref_clk_i = 1'b0; // core clock
	logic rst_b_i = 1'b0; // reset
	logic orbit_i = 1'b0; // orbit pin
	logic gap_i = 1'b0; // gap pin
	logic [3:0] adr = 4'h0; // bus address
	logic rd = 1'b0; // bus read
	logic wr = 1'b0; // bus write
	logic [31:0] wd = 32'h0; // write data
	logic [31:0] rdat; // read data
	logic wreq; // bus stall
	tmd_bp_s bp; // strobes
	tmd_stat_s st; // status
	logic [7:0] pls; // pulser fire
	logic go = 1'b0; // model start
	logic [8:0] f1 = 9'h0; // first frame
	logic [8:0] f2 = 9'h0; // second frame
	logic ser, xing, busy; // model outputs
	logic live = 1'b0; // decoder synced
	int num_errors = 0; // mismatches
	int check_count = 0; // comparisons
	int cyc = 0; // cycle count
	logic [31:0] rs = 32'h0040; // xorshift state
	logic [7:0] pen = 8'h0; // pulser enables
	logic [15:0] eq[$]; // expected strobes
	logic [31:0] rq[$]; // expected reads
	logic [15:0] key, kexp; // observed, expected
	logic [31:0] rexp; // expected read
	tmd_decoder uut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .ser_i(ser), .xing_i(xing),
		.orbit_i(orbit_i), .gap_i(gap_i), .avs_address_i(adr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdat),
		.avs_waitrequest_o(wreq), .bp_o(bp), .stat_o(st), .pulse_o(pls));
	tmd_sup_model sup (.ref_clk_i(ref_clk_i), .go_i(go), .f1_i(f1), .f2_i(f2),
		.ser_o(ser), .xing_o(xing), .busy_o(busy));
	initial begin
		forever #50 ref_clk_i = ~ref_clk_i;
	end
	function logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task end_of_test();
		if (num_errors == 0 && check_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// hang guard
	always @(posedge ref_clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			end_of_test();
		end
	end
	// bus cycle; on a read d is the expected data
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		adr <= a;
		wd <= d;
		wr <= w;
		rd <= !w;
		if (!w) rq.push_back(d);
		@(posedge ref_clk_i);
		while (wreq !== 1'b0) @(posedge ref_clk_i);
		wr <= 1'b0;
		rd <= 1'b0;
		repeat (2) @(posedge ref_clk_i);
	endtask
	// one crossing, expected strobes noted first
	task xfer(input logic [8:0] a, input logic [8:0] b, input logic g);
		logic [15:0] e;
		e = 16'h0;
		if (live) begin
			eq.push_back(((a[2] && !g) ? 16'h8000 : 16'h4000) | a[1:0]);
			case (b[TYPE_MSB:TYPE_LSB])
				TYPE_L2: e = (b[2] ? 16'h2000 : 16'h1000) | b[1:0];
				TYPE_CAL: e = 16'h0800 | pen;
				TYPE_CTL: e = (b[4:3] == 2'b00) ? 16'h0 : ((16'h0800 >> b[4:3]) | b[2:0]);
				default: e = 16'h0;
			endcase
			if (e != 0) eq.push_back(e);
			if (b[TYPE_MSB:TYPE_LSB] == TYPE_CTL && b[4:3] == CMD_RESET) live = 1'b0;
		end
		f1 <= a;
		f2 <= b;
		gap_i <= g;
		go <= 1'b1;
		@(posedge ref_clk_i);
		go <= 1'b0;
		@(posedge ref_clk_i);
		while (busy) @(posedge ref_clk_i);
		repeat (8) @(posedge ref_clk_i);
	endtask
	task orbit();
		orbit_i <= 1'b1;
		repeat (3) @(posedge ref_clk_i);
		orbit_i <= 1'b0;
		repeat (6) @(posedge ref_clk_i);
		live = 1'b1;
	endtask
	// result watcher
	always @(posedge ref_clk_i) begin
		if (rd && wreq === 1'b0) begin
			rexp = rq.pop_front();
			`CHK("readdata", rexp, rdat)
		end
		key = {bp.l1_acc, bp.l1_rej, bp.l2_acc, bp.l2_rej, bp.cal, bp.halt, bp.prst,
			bp.start, 8'h00};
		if (key[15:8] !== 8'h00) begin
			if (key[15:14] != 2'b00) key[1:0] = bp.l1_buf;
			else if (key[13:12] != 2'b00) key[1:0] = bp.l2_buf;
			else if (key[11]) key[7:0] = pls;
			else key[2:0] = bp.rdo_type;
			kexp = (eq.size() > 0) ? eq.pop_front() : 16'h0000;
			`CHK("strobes", kexp, key)
		end
	end
	initial begin
		repeat (3) @(posedge ref_clk_i);
		rst_b_i <= 1'b1;
		@(posedge ref_clk_i);
		`CHK("status", 4'b1000, st)
		bus(1'b0, 4'h2, BAD_READ);
		bus(1'b0, REG_PULSE, 32'h0);
		xfer(9'h104, {1'b1, TYPE_CTL, 6'h18}, 1'b0);
		orbit();
		rs = xs(rs);
		pen = rs[7:0] | 8'h01;
		bus(1'b1, REG_PULSE, {24'h0, pen});
		bus(1'b0, REG_PULSE, {24'h0, pen});
		for (int i = 0; i < 4; i++) begin
			rs = xs(rs);
			xfer({6'h20, rs[0], i[1:0]}, {1'b1, TYPE_L2, 3'h0, 1'b0, i[1:0]}, 1'b0);
		end
		xfer(9'h107, 9'h1FF, 1'b1);
		xfer(9'h101, {1'b1, TYPE_CAL, 6'h00}, 1'b0);
		bus(1'b1, REG_CTRL, 32'h1);
		`CHK("err", 1'b1, st.err)
		bus(1'b1, REG_CTRL, 32'h2);
		`CHK("err", 1'b0, st.err)
		for (int c = 1; c < 4; c++) begin
			rs = xs(rs);
			xfer(9'h102, {1'b1, TYPE_CTL, 1'b0, c[1:0], rs[2:0]}, 1'b0);
			if (c == 2) orbit();
		end
		bus(1'b1, REG_FULL, 32'h3);
		xfer(9'h104, {1'b1, TYPE_L2, 6'h04}, 1'b0);
		`CHK("done", 1'b0, st.done)
		`CHK("wait", 1'b1, st.wait_l)
		bus(1'b1, REG_FULL, 32'h0);
		`CHK("done", 1'b1, st.done)
		`CHK("wait", 1'b0, st.wait_l)
		repeat (10) @(posedge ref_clk_i);
		`CHK("pending", 0, eq.size())
		end_of_test();
	end
endmodule
